// ### pkg/imw_params.svh
`ifndef IMW_PARAMS_SVH
`define IMW_PARAMS_SVH

// Register offsets on the plain register port
`define IMW_OFS_CTRL    4'h0
`define IMW_OFS_MODE    4'h1
`define IMW_OFS_RATE    4'h2
`define IMW_OFS_DATA    4'h3
`define IMW_OFS_STAT    4'h4
`define IMW_OFS_CLR     4'h5
`define IMW_OFS_IEN     4'h6

// Bus control register fields
`define IMW_CTRL_EN     7
`define IMW_CTRL_MST    6
`define IMW_CTRL_FMT    5
`define IMW_CTRL_STA    4
`define IMW_CTRL_STP    3
`define IMW_CTRL_ACK    2
`define IMW_CTRL_BUSY   1
`define IMW_CTRL_IRQ    0

// Bus mode register fields
`define IMW_MODE_ORDER  7
`define IMW_MODE_WAIT   6
`define IMW_MODE_CKS_HI 5
`define IMW_MODE_CKS_LO 3

// Transfer rate control register field
`define IMW_RATE_PRE    0

// Event bits of status, clear and enable registers
`define IMW_EV_DONE     0
`define IMW_EV_WAIT     1
`define IMW_EV_STOP     2
`define IMW_EV_N        3

// Reset values
`define IMW_MODE_RST    5'h00
`define IMW_EV_RST      3'h0

// System clock divide ratios, indexed by {prescale, clock select}
`define IMW_DIV_0       9'h01C
`define IMW_DIV_1       9'h028
`define IMW_DIV_2       9'h030
`define IMW_DIV_3       9'h040
`define IMW_DIV_4       9'h050
`define IMW_DIV_5       9'h064
`define IMW_DIV_6       9'h070
`define IMW_DIV_7       9'h080
`define IMW_DIV_8       9'h038
`define IMW_DIV_9       9'h050
`define IMW_DIV_10      9'h060
`define IMW_DIV_11      9'h080
`define IMW_DIV_12      9'h0A0
`define IMW_DIV_13      9'h0C8
`define IMW_DIV_14      9'h0E0
`define IMW_DIV_15      9'h100

`endif

// ### pkg/imw_pkg.sv
`include "imw_params.svh"

package imw_pkg;

  // Serial engine states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_START = 10'h002,
    ST_READY = 10'h004,
    ST_BLO   = 10'h008,
    ST_BHI   = 10'h010,
    ST_HOLD  = 10'h020,
    ST_ALO   = 10'h040,
    ST_AHI   = 10'h080,
    ST_STOP1 = 10'h100,
    ST_STOP2 = 10'h200
  } imw_state_t;

  typedef logic [8:0] imw_ratio_t;

  // Divide ratio for a {prescale, clock select} code
  function automatic imw_ratio_t imw_ratio(input logic [3:0] code);
    unique case (code)
      4'h0: imw_ratio = `IMW_DIV_0;
      4'h1: imw_ratio = `IMW_DIV_1;
      4'h2: imw_ratio = `IMW_DIV_2;
      4'h3: imw_ratio = `IMW_DIV_3;
      4'h4: imw_ratio = `IMW_DIV_4;
      4'h5: imw_ratio = `IMW_DIV_5;
      4'h6: imw_ratio = `IMW_DIV_6;
      4'h7: imw_ratio = `IMW_DIV_7;
      4'h8: imw_ratio = `IMW_DIV_8;
      4'h9: imw_ratio = `IMW_DIV_9;
      4'hA: imw_ratio = `IMW_DIV_10;
      4'hB: imw_ratio = `IMW_DIV_11;
      4'hC: imw_ratio = `IMW_DIV_12;
      4'hD: imw_ratio = `IMW_DIV_13;
      4'hE: imw_ratio = `IMW_DIV_14;
      4'hF: imw_ratio = `IMW_DIV_15;
    endcase
  endfunction : imw_ratio

  // Data bit for position idx, MSB first or LSB first
  function automatic logic imw_pick_bit(input logic [7:0] d, input logic [2:0] idx,
                                        input logic lsb_first);
    imw_pick_bit = lsb_first ? d[idx] : d[3'h7 - idx];
  endfunction : imw_pick_bit

endpackage : imw_pkg

// ### pkg/imw_rate_if.sv
`timescale 1ns/100ps
`default_nettype none

// Rate request from the engine and half-period tick back
interface imw_rate_if;
  logic       run;
  logic [3:0] sel;
  logic       tick;
  modport ctrl (output run, output sel, input tick);
  modport div  (input run, input sel, output tick);
endinterface : imw_rate_if

`default_nettype wire

// ### design/imw_rate_div.sv
`timescale 1ns/100ps
`default_nettype none

module imw_rate_div import imw_pkg::*; #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  reset_n,
  // Rate request and tick
  imw_rate_if.div    rate
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] half;

  // Largest ratio is 256, so the half count needs at least 8 bits
  generate
    if (CNT_W < 8) begin : g_chk
      $error("imw_rate_div: CNT_W too small for the largest ratio");
    end
  endgenerate

  assign half = CNT_W'(imw_ratio(rate.sel) >> 1);

  // Tick every half serial clock period; idle while not running
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count     <= '0;
      rate.tick <= 1'b0;
    end else if (!rate.run) begin
      count     <= '0;
      rate.tick <= 1'b0;
    end else if (count >= half - CNT_W'(1)) begin // R11
      count     <= '0;
      rate.tick <= 1'b1;
    end else begin
      count     <= count + CNT_W'(1);
      rate.tick <= 1'b0;
    end
  end

  // Two ticks never stand back to back, the smallest half period is 14
  tick_gap_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
    rate.tick |=> !rate.tick) else $error("divider ticks back to back");

endmodule : imw_rate_div

`default_nettype wire

// ### design/imw_mode_ctrl.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1 - The mode register is read and written only while the module enable bit is 1.
// R2 - Bit 7 picks MSB first at 0 and LSB first at 1, and must stay 0 for the I2C format.
// R3 - The wait bit (bit 6) acts only for a master using the I2C format.
// R4 - With wait set, the falling clock of the final data bit sets the request flag.
// R5 - With wait set, the engine then holds the serial clock low before the acknowledge.
// R6 - Clearing the request flag ends the wait and the acknowledge bit is transferred.
// R7 - With wait clear, data bits and the acknowledge bit run back to back.
// R8 - The request flag is set when the acknowledge bit completes, whatever the wait bit.
// R9 - The three-bit clock select acts only in master mode.
// R10 - Clock select bits 5 to 3 join the prescale bit to choose the master rate.
// R11 - The master serial clock is the system clock divided by the chosen ratio.
// R12 - Bit order, wait and clock select fields read as 0 after reset.
module imw_mode_ctrl import imw_pkg::*; #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Serial clock pin, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  // Serial data pin, open drain
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Interrupt
  output logic            irq
);

  generate
    if (DATA_W != 8) begin : g_chk
      $error("imw_mode_ctrl: only 8 data bits per frame are served");
    end
  endgenerate

  imw_rate_if rate ();

  imw_state_t state;
  imw_state_t next_state;

  logic                 module_enable;
  logic                 master_mode;
  logic                 i2c_format;
  logic                 irq_request_flag;
  logic                 ack_seen;
  logic                 start_req;
  logic                 stop_req;
  logic                 data_req;
  logic                 bit_order_select;
  logic                 wait_insert;
  logic [2:0]           clk_select;
  logic                 rate_prescale_bit;
  logic [7:0]           data_buf;
  logic [7:0]           shreg;
  logic [2:0]           bit_idx;
  logic [`IMW_EV_N-1:0] irq_status;
  logic [`IMW_EV_N-1:0] irq_enable;
  logic [`IMW_EV_N-1:0] events;

  logic wr_ctrl, wr_mode, wr_rate, wr_data, wr_clr, wr_ien;
  logic tick, last_bit, wait_active, cur_bit;
  logic ev_wait, ev_ack, ev_ser, ev_stop;
  logic mode_ok;

  imw_rate_div #(.CNT_W(8)) u_div (
    .clock   (clock),
    .reset_n (reset_n),
    .rate    (rate.div)
  );

  // Register write decode; the mode register is locked while disabled
  assign mode_ok = module_enable; // R1
  assign wr_ctrl = reg_write && (reg_addr == `IMW_OFS_CTRL);
  assign wr_mode = reg_write && (reg_addr == `IMW_OFS_MODE) && mode_ok; // R1
  assign wr_rate = reg_write && (reg_addr == `IMW_OFS_RATE);
  assign wr_data = reg_write && (reg_addr == `IMW_OFS_DATA);
  assign wr_clr  = reg_write && (reg_addr == `IMW_OFS_CLR);
  assign wr_ien  = reg_write && (reg_addr == `IMW_OFS_IEN);

  // Engine helpers
  assign tick        = rate.tick;
  assign last_bit    = (bit_idx == 3'(DATA_W - 1));
  assign wait_active = master_mode && i2c_format && wait_insert; // R3
  assign cur_bit     = imw_pick_bit(shreg, bit_idx, bit_order_select); // R2

  // Engine events
  assign ev_wait = (state == ST_BHI) && tick && last_bit && wait_active; // R4
  assign ev_ack  = (state == ST_AHI) && tick; // R8
  assign ev_ser  = (state == ST_BHI) && tick && last_bit && !i2c_format;
  assign ev_stop = (state == ST_STOP2) && tick;
  assign events  = {ev_stop, ev_wait, ev_ack || ev_ser};

  // Divider runs only for an enabled master; slaves ignore the select
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate.run <= 1'b0;
      rate.sel <= 4'h0;
    end else begin
      rate.run <= module_enable && master_mode && (state != ST_IDLE || start_req
                  || data_req); // R9
      rate.sel <= {rate_prescale_bit, clk_select}; // R10
    end
  end

  // Control register; a hardware set of the request flag beats a clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      module_enable    <= 1'b0;
      master_mode      <= 1'b0;
      i2c_format       <= 1'b0;
      irq_request_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        module_enable <= reg_wdata[`IMW_CTRL_EN];
        master_mode   <= reg_wdata[`IMW_CTRL_MST];
        i2c_format    <= reg_wdata[`IMW_CTRL_FMT];
      end
      if (ev_wait || ev_ack || ev_ser) begin
        irq_request_flag <= 1'b1; // R4 R8
      end else if (wr_ctrl && !reg_wdata[`IMW_CTRL_IRQ]) begin
        irq_request_flag <= 1'b0; // R6
      end
    end
  end

  // Command requests, held until the engine takes them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_req <= 1'b0;
      stop_req  <= 1'b0;
      data_req  <= 1'b0;
      data_buf  <= 8'h00;
    end else begin
      if (wr_ctrl && reg_wdata[`IMW_CTRL_STA] && module_enable) begin
        start_req <= 1'b1;
      end else if (state == ST_IDLE && next_state == ST_START) begin
        start_req <= 1'b0;
      end
      if (wr_ctrl && reg_wdata[`IMW_CTRL_STP] && module_enable) begin
        stop_req <= 1'b1;
      end else if (state == ST_READY && next_state == ST_STOP1) begin
        stop_req <= 1'b0;
      end
      if (wr_data && module_enable) begin
        data_req <= 1'b1;
        data_buf <= reg_wdata;
      end else if (next_state == ST_BLO && state != ST_BHI) begin
        data_req <= 1'b0;
      end
    end
  end

  // Mode and rate registers; fields clear on reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {bit_order_select, wait_insert, clk_select} <= `IMW_MODE_RST; // R12
      rate_prescale_bit <= 1'b0;
    end else begin
      if (wr_mode) begin
        bit_order_select <= reg_wdata[`IMW_MODE_ORDER]; // R2
        wait_insert      <= reg_wdata[`IMW_MODE_WAIT];
        clk_select       <= reg_wdata[`IMW_MODE_CKS_HI:`IMW_MODE_CKS_LO];
      end
      if (wr_rate) begin
        rate_prescale_bit <= reg_wdata[`IMW_RATE_PRE];
      end
    end
  end

  // Next engine state; every step out of a state other than idle, ready or hold waits for a divider tick, except the forced return to idle when disabled or slave
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (master_mode && start_req) begin
          next_state = ST_START;
        end else if (master_mode && data_req && !i2c_format) begin
          next_state = ST_BLO;
        end
      end
      ST_START: begin
        if (tick) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (data_req) begin
          next_state = ST_BLO;
        end else if (stop_req) begin
          next_state = ST_STOP1;
        end
      end
      ST_BLO: begin
        if (tick) begin
          next_state = ST_BHI;
        end
      end
      ST_BHI: begin
        if (tick) begin
          if (!last_bit) begin
            next_state = ST_BLO;
          end else if (wait_active) begin
            next_state = ST_HOLD; // R5
          end else if (i2c_format) begin
            next_state = ST_ALO; // R7
          end else begin
            next_state = ST_READY;
          end
        end
      end
      ST_HOLD: begin
        if (!irq_request_flag) begin
          next_state = ST_ALO; // R6
        end
      end
      ST_ALO: begin
        if (tick) begin
          next_state = ST_AHI;
        end
      end
      ST_AHI: begin
        if (tick) begin
          next_state = ST_READY;
        end
      end
      ST_STOP1: begin
        if (tick) begin
          next_state = ST_STOP2;
        end
      end
      ST_STOP2: begin
        if (tick) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A slave never drives the clock, so the engine stays parked and the pins released
    if (!module_enable || !master_mode) begin
      next_state = ST_IDLE; // R9
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Pin drive and shifting; pins only ever pull low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      shreg    <= 8'h00;
      bit_idx  <= 3'h0;
      ack_seen <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      unique case (next_state)
        ST_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
        end
        ST_START: begin
          sda_oe <= 1'b1;
        end
        ST_READY: begin
          scl_oe <= 1'b1;
          if (state == ST_START) begin
            sda_oe <= 1'b1;
          end
        end
        ST_BLO: begin
          scl_oe <= 1'b1;
          if (state == ST_BHI) begin
            sda_oe  <= !imw_pick_bit(shreg, bit_idx + 3'h1, bit_order_select);
            bit_idx <= bit_idx + 3'h1;
          end else if (state != ST_BLO) begin // Load on entry only, the index must survive
            shreg   <= data_buf;
            bit_idx <= 3'h0;
            sda_oe  <= !imw_pick_bit(data_buf, 3'h0, bit_order_select);
          end
        end
        ST_BHI: begin
          scl_oe <= 1'b0;
        end
        ST_HOLD: begin
          scl_oe <= 1'b1; // R5
        end
        ST_ALO: begin
          scl_oe <= 1'b1;
          sda_oe <= 1'b0; // R6 R7
        end
        ST_AHI: begin
          scl_oe <= 1'b0;
        end
        ST_STOP1: begin
          scl_oe <= 1'b1;
          sda_oe <= 1'b1;
        end
        ST_STOP2: begin
          scl_oe <= 1'b0;
        end
      endcase
      // Acknowledge is sampled at the end of its high phase
      if (ev_ack) begin
        ack_seen <= !sda_in;
      end
    end
  end

  // Sticky status, write-one clear; a new event beats its clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= `IMW_EV_RST;
      irq_enable <= `IMW_EV_RST;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(wr_clr ? reg_wdata[`IMW_EV_N-1:0] : `IMW_EV_RST))
                    | events;
      if (wr_ien) begin
        irq_enable <= reg_wdata[`IMW_EV_N-1:0];
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_read) begin
        unique case (reg_addr)
          `IMW_OFS_CTRL: reg_rdata <= {module_enable, master_mode, i2c_format, 2'b00,
                                       ack_seen, state != ST_IDLE, irq_request_flag};
          `IMW_OFS_MODE: reg_rdata <= mode_ok ? {bit_order_select, wait_insert, clk_select,
                                                 3'b000} : 8'h00; // R1
          `IMW_OFS_RATE: reg_rdata <= {7'h00, rate_prescale_bit};
          `IMW_OFS_DATA: reg_rdata <= data_buf;
          `IMW_OFS_STAT: reg_rdata <= {5'h00, irq_status};
          `IMW_OFS_IEN:  reg_rdata <= {5'h00, irq_enable};
          default:       reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_last_fall;
    (state == ST_BHI) && tick && last_bit;
  endsequence

  mode_gate_a: assert property ( // R1
    reg_write && reg_addr == `IMW_OFS_MODE && !module_enable
    |=> $stable({bit_order_select, wait_insert, clk_select}))
    else $error("mode register changed while disabled");
  bit_order_a: assert property ( // R2
    (state == ST_BLO) && $past(state) == ST_BLO |-> sda_oe == !cur_bit)
    else $error("data pin does not follow selected bit order");
  wait_scope_a: assert property ( // R3
    (next_state == ST_HOLD) && (state != ST_HOLD) |-> master_mode && i2c_format && wait_insert)
    else $error("wait entered outside master I2C with wait set");
  wait_flag_a: assert property ( // R4
    s_last_fall ##0 (wait_active && module_enable) |=> irq_request_flag && state == ST_HOLD)
    else $error("final bit fall did not raise flag and wait");
  hold_low_a: assert property ( // R5
    (state == ST_HOLD) [*2] |-> scl_oe)
    else $error("clock not held low in wait");
  wait_end_a: assert property ( // R6
    (state == ST_HOLD) && !irq_request_flag && module_enable && master_mode
    |=> state == ST_ALO ##0 !sda_oe)
    else $error("wait did not end on flag clear");
  no_pause_a: assert property ( // R7
    s_last_fall ##0 (i2c_format && master_mode && !wait_active && module_enable)
    |=> state == ST_ALO)
    else $error("pause inserted before acknowledge");
  ack_flag_a: assert property ( // R8
    ev_ack |=> irq_request_flag)
    else $error("flag not set after acknowledge");
  slave_rate_a: assert property ( // R9
    !master_mode |=> !rate.run)
    else $error("divider runs in slave mode");
  rate_sel_a: assert property ( // R10
    ##1 rate.sel == $past({rate_prescale_bit, clk_select}))
    else $error("rate select does not match prescale and clock select");

endmodule : imw_mode_ctrl

`default_nettype wire

// ### tb/imw_bus_model.sv
`timescale 1ns/100ps
`default_nettype none

// Far-side target on the two-wire bus: captures bits, answers the acknowledge
module imw_bus_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Control from the bench
  input  wire logic       ack_on,
  // Pull on the data line and captured bits
  output logic            sda_low,
  output logic      [7:0] cap,
  output logic      [3:0] cnt
);
  logic scl_q;
  logic sda_q;

  // Lines sampled on the system clock so edges are seen without races
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      sda_low <= 1'b0;
      cap     <= 8'h00;
      cnt     <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        cnt <= 4'h0;                         // Start seen, frame restarts
      end else if (scl && !scl_q) begin
        if (cnt != 4'h8 || !ack_on) begin
          cap <= {cap[6:0], sda};            // First bit on the wire ends up in bit 7
        end
        if (cnt != 4'hF) begin
          cnt <= cnt + 4'h1;
        end
      end else if (!scl && scl_q) begin
        // Pull low for the ninth bit only; released line floats high by pull-up
        sda_low <= (cnt == 4'h8) && ack_on;
      end
    end
  end
endmodule : imw_bus_model

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "imw_params.svh"

module tb;
  logic       clock;
  logic       reset_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic       scl_out;
  logic       scl_oe;
  logic       sda_out;
  logic       sda_oe;
  logic       irq;
  logic       sda_low;
  logic       ack_on;
  logic       scl_w;
  logic       sda_w;
  logic [7:0] cap;
  logic [7:0] rd_v;
  logic [3:0] code;
  int         miscompares;
  int         checked;
  int         n;
  int         i;
  int         k;
  // Divide ratios per {prescale, clock select}, worked out independently of the design
  int ratio_tab[16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};

  // Open-drain lines with pull-ups
  assign scl_w = scl_oe ? scl_out : 1'b1;
  assign sda_w = ((sda_oe && !sda_out) || sda_low) ? 1'b0 : 1'b1;

  imw_mode_ctrl dut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq)
  );

  imw_bus_model target (
    .clock(clock), .reset_n(reset_n), .scl(scl_w), .sda(sda_w), .ack_on(ack_on),
    .sda_low(sda_low), .cap(cap), .cnt()
  );

  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask : rd

  // Bounded poll of one register bit; running out ends the run
  task automatic poll(input logic [3:0] a, input int b);
    for (int j = 0; j < 4000; j++) begin
      rd(a);
      if (rd_v[b] === 1'b1) return;
    end
    miscompares++;
    tally_and_finish();
  endtask : poll

  // Length of the first data clock high phase; the start phase is skipped, as its
  // length also holds the divider's start-up lag
  task automatic meas();
    for (i = 0; i < 3000 && scl_w !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    for ( ; i < 3000 && scl_w !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    for (n = 0; n < 3000 && scl_w === 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (i >= 3000 || n >= 3000) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : meas

  task automatic stop_and_clear();
    wr(`IMW_OFS_CTRL, 8'hE8);
    poll(`IMW_OFS_STAT, `IMW_EV_STOP);
    wr(`IMW_OFS_CLR, 8'h07);
  endtask : stop_and_clear

  initial begin
    miscompares = 0;
    checked     = 0;
    reset_n     = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_write   = 1'b0;
    reg_read    = 1'b0;
    ack_on      = 1'b1;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    // Mode register closed while the module is off, zero after reset
    wr(`IMW_OFS_MODE, 8'hF8);
    rd(`IMW_OFS_MODE); chk(rd_v, 8'h00);
    wr(`IMW_OFS_CTRL, 8'h80);
    rd(`IMW_OFS_MODE); chk(rd_v, 8'h00);
    wr(`IMW_OFS_MODE, 8'hFF);
    rd(`IMW_OFS_MODE); chk(rd_v, 8'hF8);
    wr(`IMW_OFS_CTRL, 8'h00);
    rd(`IMW_OFS_MODE); chk(rd_v, 8'h00);
    wr(`IMW_OFS_CTRL, 8'h80);
    rd(`IMW_OFS_MODE); chk(rd_v, 8'hF8);
    wr(`IMW_OFS_IEN, 8'h01);
    // Master bytes with no wait at three rates, MSB first as the bus format needs
    for (k = 0; k < 3; k++) begin
      code = (k == 0) ? 4'h0 : ((k == 1) ? 4'h6 : 4'hB);
      wr(`IMW_OFS_RATE, {7'h00, code[3]});
      wr(`IMW_OFS_MODE, {2'b00, code[2:0], 3'b000});
      wr(`IMW_OFS_CTRL, 8'hF0);
      wr(`IMW_OFS_DATA, 8'h96 + 8'(k));
      meas();
      chk(8'(n), 8'(ratio_tab[code] / 2));
      poll(`IMW_OFS_STAT, `IMW_EV_DONE);
      chk(cap, 8'h96 + 8'(k));
      rd(`IMW_OFS_STAT); chk(rd_v, 8'h01);
      rd(`IMW_OFS_CTRL); chk(rd_v & 8'h05, 8'h05);
      chk({7'h00, irq}, 8'h01);
      stop_and_clear();
    end
    repeat (2) @(posedge clock);
    #1;
    chk({7'h00, irq}, 8'h00);
    // Wait inserted before the acknowledge, then released by clearing the flag
    wr(`IMW_OFS_RATE, 8'h00);
    wr(`IMW_OFS_MODE, 8'h40);
    wr(`IMW_OFS_CTRL, 8'hF0);
    wr(`IMW_OFS_DATA, 8'h3C);
    poll(`IMW_OFS_STAT, `IMW_EV_WAIT);
    rd(`IMW_OFS_CTRL); chk(rd_v & 8'h01, 8'h01);
    n = 0;
    repeat (200) begin
      @(posedge clock);
      #1;
      if (scl_w !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    rd(`IMW_OFS_STAT); chk(rd_v, 8'h02);
    wr(`IMW_OFS_IEN, 8'h00);
    repeat (2) @(posedge clock);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr(`IMW_OFS_IEN, 8'h02);
    repeat (2) @(posedge clock);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr(`IMW_OFS_CTRL, 8'hE0);
    poll(`IMW_OFS_STAT, `IMW_EV_DONE);
    rd(`IMW_OFS_CTRL); chk(rd_v & 8'h05, 8'h05);
    chk(cap, 8'h3C);
    stop_and_clear();
    // Clocked serial format: LSB first, wait bit has no effect
    ack_on <= 1'b0;
    wr(`IMW_OFS_CTRL, 8'hC0);
    wr(`IMW_OFS_MODE, 8'hC0);
    wr(`IMW_OFS_DATA, 8'h2D);
    poll(`IMW_OFS_STAT, `IMW_EV_DONE);
    rd(`IMW_OFS_STAT); chk(rd_v, 8'h01);
    chk(cap, 8'hB4);
    wr(`IMW_OFS_CLR, 8'h07);
    // Slave mode: clock select gives no serial clock at all
    wr(`IMW_OFS_CTRL, 8'hA0);
    wr(`IMW_OFS_MODE, 8'h38);
    wr(`IMW_OFS_DATA, 8'h55);
    n = 0;
    repeat (300) begin
      @(posedge clock);
      #1;
      if (scl_oe !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    rd(`IMW_OFS_STAT); chk(rd_v, 8'h00);
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
